// ===== crs_far_model.sv
// Far side: CAN nodes raising events, trace store draining records
`timescale 1ns/1ps
module crs_far_model (
	input  wire logic              hclk,
	input  wire logic              stall,
	output crs_pkg::crs_frame_t    rx_end,
	output crs_pkg::crs_err_t      bus_err,
	output crs_pkg::crs_frame_t    tx_request,
	output crs_pkg::crs_frame_t    tx_done,
	input  wire logic              rec_valid,
	output logic                   rec_ready,
	input  wire crs_pkg::crs_rec_t rec_data
);
	import crs_pkg::*;
	logic [3:0]  v = 4'h0;
	logic [33:0] f = 34'h0;
	logic [33:0] junk = 34'h2AAAA5555;
	logic [5:0]  e = 6'h00;
	logic [7:0]  pat = 8'hED;
	crs_rec_t    got[$];
	// Idle fields churn so a stale identifier is never mistaken for data
	assign rx_end = v[0] ? {1'h1, f} : {1'h0, junk};
	assign tx_request = v[1] ? {1'h1, f} : {1'h0, junk};
	assign tx_done = v[2] ? {1'h1, f} : {1'h0, junk};
	assign bus_err = v[3] ? e : 6'h00;
	// Store stalls one cycle in four even when not held off
	always @(posedge hclk) begin
		junk <= ~junk;
		pat <= {pat[6:0], pat[7]};
		rec_ready <= ~stall & pat[0];
		if (rec_valid === 1'h1 && rec_ready === 1'h1)
			got.push_back(rec_data);
	end
	task automatic ev(input int k, input logic [33:0] fr, input logic [5:0] er);
		v <= 4'(1 << k);
		f <= fr;
		e <= er;
		@(posedge hclk);
		v <= 4'h0;
		@(posedge hclk);
	endtask : ev
endmodule : crs_far_model

// ===== crs_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module crs_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;
	assign in_ready  = (cnt_r != DEPTH[AW:0]);
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign level     = cnt_r;
	always_ff @(posedge clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule : crs_fifo

// ===== crs_pkg.sv
// Types shared by the recorder, the far-side model and the bench
package crs_pkg;
	typedef enum logic [4:0] {
		CRS_ST_OK   = 5'b00001,
		CRS_ST_RING = 5'b00010,
		CRS_ST_NEAR = 5'b00100,
		CRS_ST_FULL = 5'b01000,
		CRS_ST_ERR  = 5'b10000
	} crs_mem_st_t;
	typedef enum logic [2:0] {
		CRS_KIND_RX   = 3'h0,
		CRS_KIND_TRANSMIT_REQUEST_ENTRY = 3'h1,
		CRS_KIND_TX   = 3'h2,
		CRS_KIND_ERR  = 3'h3
	} crs_kind_t;
	typedef struct packed {
		logic        valid;
		logic        ext;
		logic [28:0] id;
		logic [3:0]  dlc;
	} crs_frame_t;
	typedef struct packed {
		logic [5:0] kinds;
	} crs_err_t;
	typedef struct packed {
		crs_kind_t   kind;
		logic        ext;
		logic [28:0] id;
		logic [3:0]  dlc;
		logic [5:0]  err;
		logic [20:0] stamp;
	} crs_rec_t;
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hsel;
	} crs_ahb_req_t;
endpackage : crs_pkg

// ===== crs_recorder.sv
// CAN recorder with storage-status logic and an AHB-Lite register slave
// What this block does
// - Ring on, storage over 95 % and protection over 90 %: nearly full.
// - Ring off and storage over 95 %: nearly full.
// - Ring off treats every stored file as protected.
// - Nearly full with unprotected files: delete oldest unprotected first.
// - Stop recording at 100 % with ring off or all files protected.
// - Memory full: indicator on, panel full line blinks once a second.
// - Logger error: indicator on, panel error word blinks once a second.
// - Accept 11-bit and 29-bit identifiers, mixed, with no setup.
// - Speed class fixed; slow 50-125 kbit/s, fast 50 kbit/s-1 Mbit/s.
// - Time stamp is taken when the frame ends.
// - Record stuff, format, ack, bit, CRC and overrun error states.
// - After 50 error records mute errors until next good frame.
// - Error records only go into the native trace format.
// - Own transmit logs a request entry, then a completed entry.
// - Formats without request entries drop them, keep completed ones.
// - Ring on, over 95 % and protection at most 90 %: ring status, overwrite oldest data.
`timescale 1ns/1ps
`include "crs_regs.svh"
module crs_recorder #(
	parameter int          DEPTH      = 32,
	parameter int          BLINK_NS   = `CRS_BLINK_NS,
	parameter logic [15:0] MAX_KBPS   = `CRS_FAST_MAX_KBPS
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire crs_pkg::crs_ahb_req_t ahb_req,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire crs_pkg::crs_frame_t rx_end,
	input  wire crs_pkg::crs_err_t   bus_err,
	input  wire crs_pkg::crs_frame_t tx_request,
	input  wire crs_pkg::crs_frame_t tx_done,
	input  wire logic [6:0]        used_pct,
	input  wire logic [6:0]        prot_pct,
	input  wire logic              unprot_present,
	input  wire logic              logger_fault,
	output logic                   delete_oldest_unprot,
	output logic                   ring_overwrite,
	output logic                   record_enable,
	output logic                   memory_led,
	output logic                   panel_full_line_on,
	output logic                   panel_error_word_on,
	output crs_pkg::crs_mem_st_t   mem_status,
	output logic                   rec_valid,
	input  wire logic              rec_ready,
	output crs_pkg::crs_rec_t      rec_data
);
	import crs_pkg::*;
	localparam int REC_W   = $bits(crs_rec_t);
	localparam int BLINK_C = (BLINK_NS / `CRS_CLK_NS > 0) ?
		BLINK_NS / `CRS_CLK_NS : 1;
	localparam int BW      = $clog2(BLINK_C + 1);

	// Control register
	logic [31:0]  ctrl_r;
	logic [15:0]  kbps_r;
	logic [20:0]  stamp_r;
	logic [5:0]   err_cnt_r;
	logic         err_mute_r;
	logic [BW-1:0] blink_cnt_r;
	logic         blink_r;
	logic         tx_pend_r;
	crs_frame_t   tx_pend_f_r;
	crs_mem_st_t  mem_st_r;
	crs_mem_st_t  mem_st_nxt;
	logic [5:0]   err_seen_r;

	wire ring_on    = ctrl_r[`CRS_CTRL_RING];
	wire native_fmt = ctrl_r[`CRS_CTRL_NATIVE];
	wire transmit_request_entry_fmt   = ctrl_r[`CRS_CTRL_TRANSMIT_REQUEST_ENTRY_OK];
	wire fast_class = ctrl_r[`CRS_CTRL_FAST];

	// Storage status decode
	wire over_near  = used_pct > `CRS_NEAR_PCT;
	wire at_full    = used_pct >= `CRS_FULL_PCT;
	// Ring off protects every file regardless of the count
	wire [6:0] eff_prot = ring_on ? prot_pct : `CRS_FULL_PCT;
	wire prot_high  = eff_prot > `CRS_PROT_PCT;
	wire all_prot   = !ring_on || !unprot_present;
	wire near_c1    = ring_on && over_near && prot_high;
	wire near_c2    = !ring_on && over_near;
	wire full_c     = at_full && all_prot;
	wire ring_c     = ring_on && over_near;
	wire fault      = logger_fault || ctrl_r[`CRS_CTRL_LOG_ERROR];

	// Severity ranking, most severe first
	assign mem_st_nxt = fault ? CRS_ST_ERR :
		full_c ? CRS_ST_FULL :
		(near_c1 || near_c2) ? CRS_ST_NEAR :
		ring_c ? CRS_ST_RING : CRS_ST_OK;

	assign mem_status   = mem_st_r;
	assign record_enable = !full_c;
	// Deleting must go on at 100 % too, or a full ring would stall
	assign delete_oldest_unprot = ring_on && over_near &&
		unprot_present;
	assign ring_overwrite = ring_c && unprot_present;
	assign memory_led = (mem_st_r == CRS_ST_FULL) ||
		(mem_st_r == CRS_ST_ERR);
	assign panel_full_line_on = (mem_st_r != CRS_ST_FULL) ||
		blink_r;
	assign panel_error_word_on = (mem_st_r != CRS_ST_ERR) ||
		blink_r;

	// Speed class bounds; rate outside the class flags unsupported
	wire [15:0] class_max = fast_class ? MAX_KBPS : `CRS_SLOW_MAX_KBPS;
	wire rate_ok = (kbps_r >= `CRS_SLOW_MIN_KBPS) &&
		(kbps_r <= class_max);

	// Record selection: error record, completion, request, received
	wire err_any   = |bus_err.kinds;
	wire err_take  = err_any && native_fmt && !err_mute_r;
	wire rx_take   = rx_end.valid && rate_ok && record_enable;
	wire txd_take  = tx_done.valid && record_enable;
	wire transmit_request_entry_take = tx_request.valid && transmit_request_entry_fmt && record_enable;
	wire           fifo_in_ready;
	crs_rec_t      rec_in;
	wire           rec_in_valid = rx_take || txd_take || transmit_request_entry_take ||
		(err_take && record_enable);
	wire [28:0] txd_id = tx_pend_r ? tx_pend_f_r.id : tx_done.id;
	always_comb begin
		rec_in       = '0;
		rec_in.stamp = stamp_r;
		if (err_take) begin
			rec_in.kind = CRS_KIND_ERR;
			rec_in.err  = bus_err.kinds;
		end else if (txd_take) begin
			rec_in.kind = CRS_KIND_TX;
			rec_in.id   = txd_id;
			rec_in.ext  = tx_done.ext;
			rec_in.dlc  = tx_done.dlc;
		end else if (transmit_request_entry_take) begin
			rec_in.kind = CRS_KIND_TRANSMIT_REQUEST_ENTRY;
			rec_in.id   = tx_request.id;
			rec_in.ext  = tx_request.ext;
			rec_in.dlc  = tx_request.dlc;
		end else begin
			rec_in.kind = CRS_KIND_RX;
			rec_in.ext  = rx_end.ext;
			rec_in.id   = rx_end.ext ? rx_end.id :
				{18'h0, rx_end.id[10:0]};
			rec_in.dlc  = rx_end.dlc;
		end
	end

	wire [$clog2(DEPTH):0] fifo_level;
	crs_rec_t              fifo_out;
	logic                  bus_pop;
	wire                   fifo_out_valid;
	crs_fifo #(.WIDTH(REC_W), .DEPTH(DEPTH)) u_fifo (
		.clk       (hclk),
		.rst_n     (hresetn),
		.in_valid  (rec_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (rec_in),
		.out_valid (fifo_out_valid),
		.out_ready (rec_ready || bus_pop),
		.out_data  (fifo_out),
		.level     (fifo_level)
	);
	assign rec_valid = fifo_out_valid;
	assign rec_data  = fifo_out;

	// Status, blink and capture bookkeeping
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_st_r    <= CRS_ST_OK;
			stamp_r     <= '0;
			blink_cnt_r <= '0;
			blink_r     <= 1'b1;
		end else begin
			mem_st_r <= mem_st_nxt;
			stamp_r  <= stamp_r + 21'd1;
			if (blink_cnt_r == BW'(BLINK_C - 1)) begin
				blink_cnt_r <= '0;
				blink_r     <= !blink_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 1'b1;
			end
		end
	end

	// Error throttle: good frame wins over a new error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_cnt_r  <= '0;
			err_mute_r <= 1'b0;
		end else if (rx_end.valid) begin
			err_cnt_r  <= '0;
			err_mute_r <= 1'b0;
		end else if (err_take && record_enable && fifo_in_ready) begin
			err_cnt_r  <= err_cnt_r + 6'd1;
			err_mute_r <= (err_cnt_r + 6'd1 >= `CRS_ERR_LIMIT);
		end
	end

	// Pending request held so the completion pairs with it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_pend_r   <= 1'b0;
			tx_pend_f_r <= '0;
			err_seen_r  <= '0;
		end else begin
			if (tx_request.valid) begin
				tx_pend_r   <= 1'b1;
				tx_pend_f_r <= tx_request;
			end else if (tx_done.valid) begin
				tx_pend_r <= 1'b0;
			end
			err_seen_r <= err_seen_r | bus_err.kinds;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	logic        ph_valid_r;
	logic        ph_write_r;
	logic [11:0] ph_addr_r;
	wire take = ahb_req.hsel && hready && ahb_req.htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r  <= '0;
		end else begin
			ph_valid_r <= take;
			ph_write_r <= ahb_req.hwrite;
			ph_addr_r  <= ahb_req.haddr[11:0];
		end
	end
	wire wr = ph_valid_r && ph_write_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= `CRS_CTRL_RESET;
			kbps_r <= `CRS_SLOW_MAX_KBPS;
		end else if (wr && ph_addr_r == `CRS_OFS_CTRL) begin
			ctrl_r <= {27'h0, hwdata[4:0]};
		end else if (wr && ph_addr_r == `CRS_OFS_BITRATE) begin
			kbps_r <= hwdata[15:0];
		end
	end
	// Read pops a record only on the data word address
	assign bus_pop = ph_valid_r && !ph_write_r &&
		ph_addr_r == `CRS_OFS_FIFO_DATA && fifo_out_valid;
	wire [31:0] rd_mux =
		(ph_addr_r == `CRS_OFS_CTRL)    ? ctrl_r :
		(ph_addr_r == `CRS_OFS_STORE)   ? {9'h0, prot_pct, 9'h0, used_pct} :
		(ph_addr_r == `CRS_OFS_STATUS)  ? {23'h0, rate_ok, record_enable,
			memory_led, 1'b0, mem_st_r} :
		(ph_addr_r == `CRS_OFS_ERRCNT)  ? {19'h0, err_seen_r, err_mute_r,
			err_cnt_r} :
		(ph_addr_r == `CRS_OFS_CAPTURE) ? {11'h0, stamp_r} :
		(ph_addr_r == `CRS_OFS_FIFO_DATA) ? {fifo_out.ext, 2'h0, fifo_out.id} :
		(ph_addr_r == `CRS_OFS_FIFO_LEVEL) ?
			{{(31 - $clog2(DEPTH)){1'b0}}, fifo_level} :
		(ph_addr_r == `CRS_OFS_BITRATE) ? {16'h0, kbps_r} : 32'h0;
	assign hrdata = ph_valid_r ? rd_mux : 32'h0;

	a_full_stops_rec: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(at_full && (!ring_on || !unprot_present)) |-> !rec_in_valid)
		else $error("recording not stopped");
	a_rank_error_top: assert property (
		@(posedge hclk) disable iff (!hresetn)
		fault |=> mem_st_r == CRS_ST_ERR) else $error("error not ranked");
	a_near_case_two: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(!ring_on && over_near && !at_full && !fault) |=>
		mem_st_r == CRS_ST_NEAR) else $error("ring off near full missed");
	a_near_case_one: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_on && over_near && prot_pct > `CRS_PROT_PCT &&
		(unprot_present || !at_full) && !fault) |=>
		mem_st_r == CRS_ST_NEAR) else $error("ring on near full missed");
	a_ring_status: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(ring_on && over_near && prot_pct <= `CRS_PROT_PCT &&
		(unprot_present || !at_full) && !fault) |=>
		mem_st_r == CRS_ST_RING) else $error("ring status missed");
	a_led_on_full: assert property (
		@(posedge hclk) disable iff (!hresetn)
		mem_st_r == CRS_ST_FULL |-> memory_led) else $error("led off");
	a_err_mute_hold: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(err_cnt_r >= `CRS_ERR_LIMIT && !rx_end.valid) |=> err_mute_r)
		else $error("error throttle missed");
	a_transmit_request_entry_dropped: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(tx_request.valid && !transmit_request_entry_fmt && !rx_end.valid &&
		!tx_done.valid && !err_any) |-> !rec_in_valid)
		else $error("request kept");
	a_err_native: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(err_any && !native_fmt && !rx_end.valid && !tx_done.valid &&
		!tx_request.valid) |-> !rec_in_valid)
		else $error("error in foreign format");
	c_full: cover property (@(posedge hclk) mem_st_r == CRS_ST_FULL);
	c_mute: cover property (@(posedge hclk) err_mute_r);
	c_txpair: cover property (@(posedge hclk) transmit_request_entry_take ##[1:20] txd_take);
	c_fifo_full: cover property (@(posedge hclk) !fifo_in_ready);
endmodule : crs_recorder

// ===== crs_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
`define CRS_OFS_CTRL        12'h000
`define CRS_OFS_STORE       12'h004
`define CRS_OFS_STATUS      12'h008
`define CRS_OFS_ERRCNT      12'h00C
`define CRS_OFS_CAPTURE     12'h010
`define CRS_OFS_FIFO_DATA   12'h014
`define CRS_OFS_FIFO_LEVEL  12'h018
`define CRS_OFS_BITRATE     12'h01C
`define CRS_CTRL_RING       0
`define CRS_CTRL_NATIVE     1
`define CRS_CTRL_TRANSMIT_REQUEST_ENTRY_OK    2
`define CRS_CTRL_LOG_ERROR  3
`define CRS_CTRL_FAST       4
`define CRS_CTRL_RESET      32'h0000_0001
`define CRS_NEAR_PCT        7'd95
`define CRS_PROT_PCT        7'd90
`define CRS_FULL_PCT        7'd100
`define CRS_ERR_LIMIT       6'd50
`define CRS_BLINK_NS        1000000000
`define CRS_CLK_NS          4
`define CRS_SLOW_MIN_KBPS   16'd50
`define CRS_SLOW_MAX_KBPS   16'd125
`define CRS_FAST_MAX_KBPS   16'd1000
`endif

// ===== tb_top.sv
// Self-checking bench for the CAN recorder with storage status
`timescale 1ns/1ps
`include "crs_regs.svh"
module tb_top;
	import crs_pkg::*;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        unprot_present = 1'h0;
	logic        logger_fault = 1'h0;
	logic        stall = 1'h0;
	logic        hready, hreadyout, hresp, del_o, ovw_o, rec_en, led;
	logic        full_on, err_on, rec_valid, rec_ready;
	logic [6:0]  used_pct = 7'h00;
	logic [6:0]  prot_pct = 7'h00;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic [31:0] rnd = 32'h59F9;
	logic [15:0] kb[7] = '{16'h32, 16'h7D, 16'h7E, 16'h31, 16'h32,
		16'h3E8, 16'h3E9};
	logic        kf[7] = '{0, 0, 0, 0, 1, 1, 1};
	logic        ka[7] = '{1, 1, 0, 0, 1, 1, 0};
	crs_ahb_req_t ahb_req = '0;
	crs_frame_t  rx_end, tx_request, tx_done;
	crs_err_t    bus_err;
	crs_rec_t    rec_data;
	crs_mem_st_t mem_status;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cyc = 0;
	assign hready = hreadyout;
	crs_recorder #(.BLINK_NS(40)) dut_u (.hclk, .hresetn, .ahb_req,
		.hready, .hwdata, .hrdata, .hreadyout, .hresp, .rx_end, .bus_err,
		.tx_request, .tx_done, .used_pct, .prot_pct, .unprot_present,
		.logger_fault, .delete_oldest_unprot(del_o),
		.ring_overwrite(ovw_o), .record_enable(rec_en), .memory_led(led),
		.panel_full_line_on(full_on), .panel_error_word_on(err_on),
		.mem_status, .rec_valid, .rec_ready, .rec_data);
	crs_far_model far_u (.hclk, .stall, .rx_end, .bus_err, .tx_request,
		.tx_done, .rec_valid, .rec_ready, .rec_data);
	initial forever #2 hclk = ~hclk;
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(input logic [63:0] s, input logic [63:0] x);
		num_checks++;
		if (s !== x) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask : chk
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// Slave answer time is not assumed: each phase waits for hready
	task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		ahb_req <= {32'(a), 2'h2, w, 3'h2, 1'h1};
		do @(posedge hclk);
		while (hready !== 1'h1);
		ahb_req <= '0;
		hwdata <= d;
		do @(posedge hclk);
		while (hready !== 1'h1);
		rd = hrdata;
	endtask : ahb
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
		ahb(1'h0, a, 32'h0);
		chk(rd, x);
		chk(hresp, 1'h0);
	endtask : rd_chk
	function automatic logic [4:0] exp_st(input logic r, input logic [6:0] u,
		input logic [6:0] p, input logic un, input logic f);
		if (f) return 5'h10;
		if (u >= 7'h64 && (!r || !un)) return 5'h08;
		if (u > 7'h5F && (!r || p > 7'h5A)) return 5'h04;
		if (u > 7'h5F) return 5'h02;
		return 5'h01;
	endfunction : exp_st
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (3) @(posedge hclk);
		while (rec_valid !== 1'h0 && n < 400) begin
			@(posedge hclk);
			n++;
		end
		chk(n < 400, 1);
	endtask : wait_idle
	task automatic take(input crs_kind_t k, input logic [33:0] f,
		input logic [5:0] e, output logic [20:0] s);
		crs_rec_t r;
		s = 21'h0;
		chk(far_u.got.size() > 0, 1);
		if (far_u.got.size() > 0) begin
			r = far_u.got.pop_front();
			s = r.stamp;
			if (k == CRS_KIND_ERR) chk({r.kind, r.err}, {k, e});
			else chk({r.kind, r.ext, r.id, r.dlc}, {k, f});
		end
	endtask : take
	task automatic blink(input logic sel);
		logic v, s;
		int n;
		n = 0;
		// Let the status register settle so only the blink can flip the line
		repeat (3) @(posedge hclk);
		v = sel ? err_on : full_on;
		do begin
			@(posedge hclk);
			n++;
			s = sel ? err_on : full_on;
		end while (s === v && n < 30);
		chk(n < 30, 1);
		for (int k = 1; k <= 20; k++) begin
			@(posedge hclk);
			chk(sel ? err_on : full_on, s ^ 1'((k / 10) % 2));
			chk(led, 1);
		end
	endtask : blink
	initial begin
		logic [20:0] s0, s1;
		logic [6:0]  u, p;
		logic [4:0]  st;
		logic        ring, un, f;
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd_chk(`CRS_OFS_CTRL, `CRS_CTRL_RESET);
		rd_chk(`CRS_OFS_BITRATE, 32'h7D);
		ahb(1'h1, 12'h020, 32'hFFFFFFFF);
		rd_chk(12'h020, 32'h0);
		chk(mem_status, 5'h01);
		for (int i = 0; i < 48; i++) begin
			rnd = xs(rnd);
			{ring, un, f} = {rnd[20], rnd[11], rnd[15:12] == 4'h0};
			u = rnd[2] ? 7'h5E + 7'(rnd[5:3]) : 7'(rnd[15:0] % 16'h65);
			if (u > 7'h64) u = 7'h64;
			p = rnd[8] ? 7'h59 + 7'(rnd[10:9]) : 7'(rnd[31:16] % 16'h65);
			ahb(1'h1, `CRS_OFS_CTRL, {27'h0, 4'h3, ring});
			{used_pct, prot_pct, unprot_present, logger_fault} <= {u, p, un, f};
			repeat (3) @(posedge hclk);
			st = exp_st(ring, u, p, un, f);
			chk(mem_status, st);
			chk(led, st[4] | st[3]);
			if (!f) chk(rec_en, !st[3]);
			if (st == 5'h04) chk(del_o, ring & un);
			if (st == 5'h02) chk(ovw_o, un);
		end
		ahb(1'h1, `CRS_OFS_CTRL, 32'h6);
		{used_pct, logger_fault} <= {7'h64, 1'h0};
		blink(1'h0);
		logger_fault <= 1'h1;
		blink(1'h1);
		{used_pct, logger_fault} <= {7'h00, 1'h0};
		wait_idle;
		far_u.got.delete();
		far_u.ev(0, {1'h0, 29'h7FF, 4'h8}, 6'h00);
		repeat (5) @(posedge hclk);
		far_u.ev(0, {1'h1, 29'h1ABCDEF0, 4'h3}, 6'h00);
		wait_idle;
		take(CRS_KIND_RX, {1'h0, 29'h7FF, 4'h8}, 6'h00, s0);
		take(CRS_KIND_RX, {1'h1, 29'h1ABCDEF0, 4'h3}, 6'h00, s1);
		chk(21'(s1 - s0), 21'h7);
		for (int i = 0; i < 7; i++) begin
			ahb(1'h1, `CRS_OFS_CTRL, {27'h0, kf[i], 4'h6});
			ahb(1'h1, `CRS_OFS_BITRATE, {16'h0, kb[i]});
			far_u.ev(0, {1'h0, 29'h123, 4'h1}, 6'h00);
			wait_idle;
			chk(far_u.got.size(), ka[i]);
			far_u.got.delete();
		end
		ahb(1'h1, `CRS_OFS_CTRL, 32'h6);
		ahb(1'h1, `CRS_OFS_BITRATE, 32'h7D);
		for (int i = 1; i >= 0; i--) begin
			far_u.ev(1, {1'h1, 29'h0ABCDE, 4'h2}, 6'h00);
			far_u.ev(2, {1'h1, 29'h0ABCDE, 4'h2}, 6'h00);
			wait_idle;
			if (i) take(CRS_KIND_TRANSMIT_REQUEST_ENTRY, {1'h1, 29'h0ABCDE, 4'h2}, 6'h00, s0);
			take(CRS_KIND_TX, {1'h1, 29'h0ABCDE, 4'h2}, 6'h00, s1);
			chk(far_u.got.size(), 0);
			ahb(1'h1, `CRS_OFS_CTRL, 32'h2);
		end
		ahb(1'h1, `CRS_OFS_CTRL, 32'h0);
		for (int k = 0; k < 6; k++) far_u.ev(3, 34'h0, 6'(1 << k));
		wait_idle;
		chk(far_u.got.size(), 0);
		ahb(1'h1, `CRS_OFS_CTRL, 32'h2);
		far_u.ev(0, {1'h0, 29'h55, 4'h0}, 6'h00);
		for (int k = 0; k < 55; k++) far_u.ev(3, 34'h0, 6'(1 << (k % 6)));
		far_u.ev(0, {1'h0, 29'h55, 4'h0}, 6'h00);
		far_u.ev(3, 34'h0, 6'h10);
		wait_idle;
		take(CRS_KIND_RX, {1'h0, 29'h55, 4'h0}, 6'h00, s0);
		for (int k = 0; k < 50; k++) take(CRS_KIND_ERR, 34'h0, 6'(1 << (k % 6)), s0);
		take(CRS_KIND_RX, {1'h0, 29'h55, 4'h0}, 6'h00, s0);
		take(CRS_KIND_ERR, 34'h0, 6'h10, s0);
		chk(far_u.got.size(), 0);
		stall <= 1'h1;
		for (int k = 0; k < 36; k++) far_u.ev(0, {1'h0, 29'h9, 4'h9}, 6'h00);
		rd_chk(`CRS_OFS_FIFO_LEVEL, 32'h20);
		chk(rec_valid, 1);
		rd_chk(`CRS_OFS_FIFO_DATA, 32'h9);
		stall <= 1'h0;
		wait_idle;
		chk(far_u.got.size(), 31);
		used_pct <= 7'h64;
		far_u.ev(0, {1'h0, 29'h9, 4'h9}, 6'h00);
		wait_idle;
		chk(far_u.got.size(), 31);
		rd_chk(`CRS_OFS_STATUS, 32'h148);
		test_done();
	end
endmodule : tb_top
